// file: core/cia_defs.vh
/*
  Constants for the instruction execute block: opcodes, special
  register addresses, field positions, reset values and memory depth.
  Assumes it is included by bare name from the design file.
*/
`ifndef CIA_DEFS_VH
`define CIA_DEFS_VH

// ---------------------------------------------------------------
// opcodes (full byte or masked group)
// ---------------------------------------------------------------
`define CIA_OP_ADD_CY_HI 4'h3
`define CIA_OP_AND_HI 4'h5
`define CIA_OP_CMP_JMP_HI 4'hB
`define CIA_OP_AND_DIR_A 8'h52
`define CIA_OP_AND_DIR_IMM 8'h53
`define CIA_OP_AND_C_BIT 8'h82
`define CIA_OP_AND_C_NBIT 8'hB0
`define CIA_OP_ZERO_A 8'hE4
`define CIA_OP_ZERO_C 8'hC3
`define CIA_OP_ZERO_BIT 8'hC2
`define CIA_OP_INV_A 8'hF4
`define CIA_OP_INV_C 8'hB3
`define CIA_OP_INV_BIT 8'hB2
`define CIA_OP_PAGE_JMP_LOW 5'h01

// ---------------------------------------------------------------
// special register addresses and bit area
// ---------------------------------------------------------------
`define CIA_ADDR_PORT 8'h90
`define CIA_ADDR_STAT 8'hD0
`define CIA_ADDR_ACC 8'hE0
`define CIA_BIT_AREA_HI 4'h2

// ---------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------
`define CIA_STAT_CY 7
`define CIA_STAT_AC 6
`define CIA_STAT_RS_HI 4
`define CIA_STAT_RS_LO 3
`define CIA_STAT_OV 2
`define CIA_STAT_P 0

// ---------------------------------------------------------------
// reset values and memory depth
// ---------------------------------------------------------------
`define CIA_RST_PC 16'h0000
`define CIA_RST_BYTE 8'h00
`define CIA_RST_PORT 8'hFF
`define CIA_RAM_DEPTH 128

`endif

// file: core/cia_core.v
/*
  Execute block for add-with-carry, absolute jump, logical and
  (byte and bit), compare-jump-not-equal, clear and complement.
  One clock edge is one machine cycle. Program memory is read
  combinationally: the three bytes at code_addr_o arrive on
  code_b0_i..code_b2_i in the same cycle. Port pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cia_defs.vh"

// Contract
// - add-with-carry adds acc, carry and source into acc in one cycle.
// - absolute jump: pc plus two, then upper five pc bits, opcode 7-5, byte two.
// - byte and stores operand and into destination, flags untouched.
// - read-modify-write on the port reads the output latch, not pins.
// - byte and opcodes decoded; direct,immediate form is three bytes, two cycles.
// - bit and clears carry on zero source; inverted form uses complement; two cycles.
// - bit and source is a direct bit only; only carry may change.
// - compare-jump: pc plus three, add signed offset when operands differ.
// - compare-jump sets carry when first operand is below second, else clears.
// - compare-jump forms decoded, each three bytes and two cycles.
// - clear accumulator in one byte and one cycle, no flag change.
// - clear carry (one byte) or direct bit (two bytes), one cycle each.
// - complement accumulator bitwise in one cycle, no flag change.
// - complement carry or a direct bit, no other flag change.
// - parity recomputed from the accumulator after every cycle.
module cia_core (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // program memory
  output reg [15:0] code_addr_o,
  input wire [7:0] code_b0_i,
  input wire [7:0] code_b1_i,
  input wire [7:0] code_b2_i,
  // i/o port
  input wire [7:0] port_pins_i,
  output reg [7:0] port_o,
  // visible state
  output reg [7:0] acc_o,
  output reg [7:0] program_status_word_o,
  output reg unsupported_o
);

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  localparam ST_EXEC = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] ram_r [0:`CIA_RAM_DEPTH-1];
  reg [7:0] pins_s1_r;
  reg [7:0] pins_s2_r;

  // ---------------------------------------------------------------
  // operand fetch
  // ---------------------------------------------------------------
  wire [7:0] op = code_b0_i;
  wire [7:0] b1 = code_b1_i;
  wire [7:0] b2 = code_b2_i;
  wire cy = program_status_word_o[`CIA_STAT_CY];
  wire [1:0] rs = program_status_word_o[`CIA_STAT_RS_HI:`CIA_STAT_RS_LO];
  // working registers sit in the bank chosen by the status word
  wire [7:0] wreg_val = ram_r[{2'b00, rs, op[2:0]}];
  wire [7:0] ptr_val = ram_r[{2'b00, rs, 2'b00, op[0]}];
  // pointer bit 7 is dropped: indirect access reaches only the low ram
  wire [7:0] ind_val = ram_r[ptr_val[6:0]];
  // bit address below 80h maps into the bit area, above into registers
  wire [7:0] bit_byte = b1[7] ? {b1[7:3], 3'b000} : {`CIA_BIT_AREA_HI, b1[6:3]};

  // direct read; rmw selects the port latch instead of the pins
  function [7:0] dir_read;
    input [7:0] a;
    input rmw;
    begin
      if (a[7] == 1'b0) begin
        dir_read = ram_r[a[6:0]];
      end else if (a == `CIA_ADDR_ACC) begin
        dir_read = acc_o;
      end else if (a == `CIA_ADDR_STAT) begin
        // status word reads back whole, parity included
        dir_read = program_status_word_o;
      end else if (a == `CIA_ADDR_PORT) begin
        dir_read = rmw ? port_o : pins_s2_r;
      end else begin
        dir_read = `CIA_RST_BYTE;
      end
    end
  endfunction

  wire [7:0] dir_pin = dir_read(b1, 1'b0);
  wire [7:0] dir_latch = dir_read(b1, 1'b1);
  wire [7:0] bit_pin_byte = dir_read(bit_byte, 1'b0);
  wire [7:0] bit_latch_byte = dir_read(bit_byte, 1'b1);
  wire bit_val = bit_pin_byte[b1[2:0]];

  // source for accumulator forms selected by low nibble
  reg [7:0] src;
  always @* begin
    case (op[3:0])
      4'h4: src = b1;
      4'h5: src = dir_pin;
      4'h6, 4'h7: src = ind_val;
      default: src = wreg_val;
    endcase
  end

  // ---------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------
  wire [8:0] sum9 = {1'b0, acc_o} + {1'b0, src} + {8'h00, cy};
  wire [4:0] sum_lo = {1'b0, acc_o[3:0]} + {1'b0, src[3:0]} + {4'h0, cy};
  wire [7:0] sum_6 = {1'b0, acc_o[6:0]} + {1'b0, src[6:0]} + {7'h00, cy};
  wire [15:0] pc2 = code_addr_o + 16'h0002;
  wire [15:0] pc3 = code_addr_o + 16'h0003;
  wire [15:0] rel_ext = {{8{b2[7]}}, b2};
  // compare operands: first is acc, register or indirect; second direct or immediate
  reg [7:0] cmp_a;
  reg [7:0] cmp_b;
  always @* begin
    case (op[3:0])
      4'h5: begin
        cmp_a = acc_o;
        cmp_b = dir_pin;
      end
      4'h4: begin
        cmp_a = acc_o;
        cmp_b = b1;
      end
      4'h6, 4'h7: begin
        cmp_a = ind_val;
        cmp_b = b1;
      end
      default: begin
        cmp_a = wreg_val;
        cmp_b = b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // decode and execute
  // ---------------------------------------------------------------
  reg [7:0] acc_nxt;
  reg [7:0] stat_nxt;
  reg [15:0] pc_nxt;
  reg we;
  reg [7:0] wa;
  reg [7:0] wd;
  reg two_cyc;
  reg unsup;
  reg [7:0] acc_fin;
  reg [7:0] stat_fin;

  // decode: defaults are next address, no write, one cycle
  always @* begin
    acc_nxt = acc_o;
    stat_nxt = program_status_word_o;
    pc_nxt = code_addr_o + 16'h0001;
    we = 1'b0;
    wa = b1;
    wd = `CIA_RST_BYTE;
    two_cyc = 1'b0;
    unsup = 1'b0;
    if (op[4:0] == `CIA_OP_PAGE_JMP_LOW) begin
      // target stays in the 2K page of the following op
      pc_nxt = {pc2[15:11], op[7:5], b1};
      two_cyc = 1'b1;
    end else if (op[7:4] == `CIA_OP_ADD_CY_HI && (op[3] || op[2])) begin
      // overflow is the carry out of bit 7 against that out of bit 6
      acc_nxt = sum9[7:0];
      stat_nxt[`CIA_STAT_CY] = sum9[8];
      stat_nxt[`CIA_STAT_AC] = sum_lo[4];
      stat_nxt[`CIA_STAT_OV] = sum9[8] ^ sum_6[7];
      pc_nxt = (op[3:0] == 4'h4 || op[3:0] == 4'h5) ? pc2 : code_addr_o + 16'h0001;
    end else if (op == `CIA_OP_AND_DIR_A) begin
      // destination read from the latch so pin levels never leak in
      we = 1'b1;
      wd = dir_latch & acc_o;
      pc_nxt = pc2;
    end else if (op == `CIA_OP_AND_DIR_IMM) begin
      we = 1'b1;
      wd = dir_latch & b2;
      pc_nxt = pc3;
      two_cyc = 1'b1;
    end else if (op[7:4] == `CIA_OP_AND_HI && (op[3] || op[2])) begin
      // working register, direct, indirect and immediate sources
      acc_nxt = acc_o & src;
      pc_nxt = (op[3:0] == 4'h4 || op[3:0] == 4'h5) ? pc2 : code_addr_o + 16'h0001;
    end else if (op == `CIA_OP_AND_C_BIT || op == `CIA_OP_AND_C_NBIT) begin
      // only carry may move; source bit is read, never written
      if ((op == `CIA_OP_AND_C_BIT) ? !bit_val : bit_val) begin
        stat_nxt[`CIA_STAT_CY] = 1'b0;
      end
      pc_nxt = pc2;
      two_cyc = 1'b1;
    end else if (op[7:4] == `CIA_OP_CMP_JMP_HI && (op[3] || op[2])) begin
      // neither operand is written; only carry and address move
      stat_nxt[`CIA_STAT_CY] = (cmp_a < cmp_b);
      pc_nxt = (cmp_a != cmp_b) ? pc3 + rel_ext : pc3;
      two_cyc = 1'b1;
    end else if (op == `CIA_OP_ZERO_A) begin
      acc_nxt = `CIA_RST_BYTE;
    end else if (op == `CIA_OP_INV_A) begin
      acc_nxt = ~acc_o;
    end else if (op == `CIA_OP_ZERO_C) begin
      stat_nxt[`CIA_STAT_CY] = 1'b0;
    end else if (op == `CIA_OP_INV_C) begin
      stat_nxt[`CIA_STAT_CY] = ~cy;
    end else if (op == `CIA_OP_ZERO_BIT || op == `CIA_OP_INV_BIT) begin
      // byte rewritten whole; the other seven bits come back from the latch
      we = 1'b1;
      wa = bit_byte;
      wd = bit_latch_byte;
      wd[b1[2:0]] = (op == `CIA_OP_INV_BIT) ? ~bit_latch_byte[b1[2:0]] : 1'b0;
      pc_nxt = pc2;
    end else begin
      // anything else is a one-byte no-op flagged to the outside
      unsup = 1'b1;
    end
    // a direct write to acc or status word overrides the computed value
    acc_fin = (we && wa == `CIA_ADDR_ACC) ? wd : acc_nxt;
    stat_fin = (we && wa == `CIA_ADDR_STAT) ? wd : stat_nxt;
    // parity follows the final acc, even after a direct status write
    stat_fin[`CIA_STAT_P] = ^acc_fin;
    // a two-cycle op parks in the wait state for one edge
    state_nxt = (two_cyc) ? ST_WAIT : ST_EXEC;
  end

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  // two stages before anything samples the pins
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      pins_s1_r <= `CIA_RST_BYTE;
      pins_s2_r <= `CIA_RST_BYTE;
    end else begin
      pins_s1_r <= port_pins_i;
      pins_s2_r <= pins_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // architectural state
  // ---------------------------------------------------------------
  // all state moves in the execute cycle; the wait cycle only pads time
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= ST_EXEC;
      code_addr_o <= `CIA_RST_PC;
      acc_o <= `CIA_RST_BYTE;
      program_status_word_o <= `CIA_RST_BYTE;
      port_o <= `CIA_RST_PORT;
      unsupported_o <= 1'b0;
    end else begin
      case (state_r)
        ST_EXEC: begin
          state_r <= state_nxt;
          code_addr_o <= pc_nxt;
          acc_o <= acc_fin;
          program_status_word_o <= stat_fin;
          unsupported_o <= unsup;
          if (we && wa == `CIA_ADDR_PORT) begin
            port_o <= wd;
          end
        end
        // bytes on the code inputs are ignored here
        ST_WAIT: begin
          state_r <= ST_EXEC;
          unsupported_o <= 1'b0;
        end
        default: begin
          state_r <= ST_EXEC;
          unsupported_o <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // internal data memory
  // ---------------------------------------------------------------
  // one write port shared by byte and bit writes to the low half
  genvar g;
  generate
    for (g = 0; g < `CIA_RAM_DEPTH; g = g + 1) begin : g_ram
      always @(posedge core_clk_i) begin
        if (reset_i) begin
          ram_r[g] <= `CIA_RST_BYTE;
        end else if (state_r == ST_EXEC && we && !wa[7] && wa[6:0] == g) begin
          ram_r[g] <= wd;
        end
      end
    end
  endgenerate

endmodule // cia_core
`default_nettype wire

// file: verification/cia_core_properties.sv
/*
  Checker for the execute block: results of add, jump, compare, complement and bit-and ops; wait-cycle timing.
  Assumes one clock, a synchronous high reset and a bind onto cia_core.
*/
`timescale 1ns/1ps
`default_nettype none
module cia_core_checker (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // program memory
  input wire logic [15:0] code_addr_o,
  input wire logic [7:0] code_b0_i,
  input wire logic [7:0] code_b1_i,
  input wire logic [7:0] code_b2_i,
  // visible state
  input wire logic [7:0] acc_o,
  input wire logic [7:0] program_status_word_o
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic wait_r, wait_nxt, cy_r, two_op;
  logic [7:0] acc_r, b0_r, b1_r, b2_r;
  logic [15:0] pc_r, pc2, pc3;
  wire exec = !wait_r;
  // two-cycle ops leave one cycle in which the bytes are ignored
  assign two_op = code_b0_i[4:0] == 5'h01 || code_b0_i == 8'h53 || code_b0_i == 8'h82;
  assign wait_nxt = exec && (two_op || code_b0_i == 8'hB0 ||
    (code_b0_i[7:4] == 4'hB && code_b0_i[3:2] != 2'b00));
  assign pc2 = pc_r + 16'h0002;
  assign pc3 = pc_r + 16'h0003 + {{8{b2_r[7]}}, b2_r};
  // values seen when an op was taken, for comparison one cycle on
  always @(posedge core_clk_i) begin
    wait_r <= wait_nxt && !reset_i;
    acc_r <= acc_o;
    cy_r <= program_status_word_o[7];
    pc_r <= code_addr_o;
    b0_r <= code_b0_i;
    b1_r <= code_b1_i;
    b2_r <= code_b2_i;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_issue2;
    wait_nxt;
  endsequence
  sequence s_hold;
    $stable(code_addr_o) && $stable(acc_o);
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_parity_tracks: assert property (program_status_word_o[0] == ^acc_o)
    else $error("parity differs from acc");
  a_carry_add_sum: assert property (exec && code_b0_i == 8'h34 |=>
    acc_o == acc_r + b1_r + {7'h00, cy_r}) else $error("add with carry sum wrong");
  a_page_jump_target: assert property (exec && code_b0_i[4:0] == 5'h01 |=>
    code_addr_o == {pc2[15:11], b0_r[7:5], b1_r}) else $error("jump target wrong");
  a_wait_cycle: assert property (s_issue2 |=> ##1 s_hold)
    else $error("state moved in wait cycle");
  a_compare_carry: assert property (exec && code_b0_i == 8'hB4 |=>
    program_status_word_o[7] == (acc_r < b1_r)) else $error("compare carry wrong");
  a_compare_target: assert property (exec && code_b0_i == 8'hB4 |=>
    code_addr_o == (acc_r != b1_r ? pc3 : pc_r + 16'h0003)) else $error("branch wrong");
  a_invert_acc: assert property (exec && code_b0_i == 8'hF4 |=>
    acc_o == ~acc_r && program_status_word_o[7] == cy_r) else $error("acc complement wrong");
  a_invert_carry: assert property (exec && code_b0_i == 8'hB3 |=>
    program_status_word_o[7] == !cy_r && acc_o == acc_r) else $error("carry complement wrong");
  a_bit_and_acc: assert property (exec && code_b0_i == 8'h82 && code_b1_i[7:3] == 5'h1C |=>
    program_status_word_o[7] == (cy_r & acc_r[b1_r[2:0]])) else $error("bit and wrong");
endmodule // cia_core_checker

bind cia_core cia_core_checker i_chk (.core_clk_i, .reset_i, .code_addr_o, .code_b0_i,
  .code_b1_i, .code_b2_i, .acc_o, .program_status_word_o);
`default_nettype wire

// file: verification/cpu_instr_add_with_carry_to_cpl_tb.sv
/*
  Testbench for the execute block: hand-written op sequences.
  Assumes the bench plays program memory, one op at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`define CIA_CK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("FAIL %0t got %h want %h", $time, g, e); \
    end \
  end
module cpu_instr_add_with_carry_to_cpl_tb;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] code_b0_i = 8'hA5;
  logic [7:0] code_b1_i = 8'h00;
  logic [7:0] code_b2_i = 8'h00;
  logic [7:0] port_pins_i = 8'h00;
  wire [15:0] code_addr_o;
  wire [7:0] port_o, acc_o, program_status_word_o;
  wire unsupported_o;
  int mismatches = 0;
  int checked = 0;
  logic [15:0] p;
  cia_core i_dut (.core_clk_i, .reset_i, .code_addr_o, .code_b0_i, .code_b1_i, .code_b2_i,
    .port_pins_i, .port_o, .acc_o, .program_status_word_o, .unsupported_o);
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // A5 is outside the set: a harmless filler so no op runs twice
  task run(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input int n);
    @(posedge core_clk_i);
    code_b0_i <= a;
    code_b1_i <= b;
    code_b2_i <= c;
    repeat (n) @(posedge core_clk_i);
    code_b0_i <= 8'hA5;
    @(negedge core_clk_i);
  endtask
  task ck2(input logic [7:0] a, input logic [7:0] s);
    `CIA_CK(acc_o, a)
    `CIA_CK(program_status_word_o, s)
    `CIA_CK(unsupported_o, 1'b0)
  endtask
  task cj(input logic [7:0] a, b, c, input logic [15:0] off, input logic cy);
    p = code_addr_o + 16'h0001;
    run(a, b, c, 2);
    `CIA_CK(code_addr_o, p + off)
    `CIA_CK(program_status_word_o, {cy, 7'h00})
    `CIA_CK(acc_o, 8'hFF)
  endtask
  task test_done;
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(negedge core_clk_i);
    ck2(8'h00, 8'h00);
    `CIA_CK(port_o, 8'hFF)
    `CIA_CK(code_addr_o, 16'h0000)
    // the filler byte is outside the set: one-cycle flag, address plus one
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    `CIA_CK(unsupported_o, 1'b1)
    `CIA_CK(code_addr_o, 16'h0001)
  endtask
  task t_acc;
    run(8'hF4, 8'h00, 8'h00, 1);
    ck2(8'hFF, 8'h00);
    run(8'h54, 8'hC7, 8'h00, 1);
    ck2(8'hC7, 8'h01);
    run(8'hE4, 8'h00, 8'h00, 1);
    ck2(8'h00, 8'h00);
  endtask
  task t_add_carry;
    run(8'hB3, 8'h00, 8'h00, 1);
    ck2(8'h00, 8'h80);
    run(8'hF4, 8'h00, 8'h00, 1);
    run(8'h54, 8'hC3, 8'h00, 1);
    ck2(8'hC3, 8'h80);
    run(8'h34, 8'hAA, 8'h00, 1);
    ck2(8'h6E, 8'h85);
    run(8'hC3, 8'h00, 8'h00, 1);
    ck2(8'h6E, 8'h05);
    run(8'h35, 8'hE0, 8'h00, 1);
    ck2(8'hDC, 8'h45);
    run(8'h36, 8'h00, 8'h00, 1);
    ck2(8'hDC, 8'h01);
  endtask
  // pins differ from the latch, so a pin read shows up at once
  task t_port;
    @(posedge core_clk_i);
    port_pins_i <= 8'h3C;
    run(8'h53, 8'h90, 8'hF3, 2);
    `CIA_CK(port_o, 8'hF3)
    run(8'h52, 8'h90, 8'h00, 1);
    `CIA_CK(port_o, 8'hD0)
    run(8'hC2, 8'h94, 8'h00, 1);
    `CIA_CK(port_o, 8'hC0)
    run(8'hB2, 8'h95, 8'h00, 1);
    `CIA_CK(port_o, 8'hE0)
    run(8'h55, 8'h90, 8'h00, 1);
    ck2(8'h1C, 8'h01);
    run(8'h58, 8'h00, 8'h00, 1);
    ck2(8'h00, 8'h00);
  endtask
  task t_bit;
    run(8'hB3, 8'h00, 8'h00, 1);
    run(8'hB0, 8'hE7, 8'h00, 2);
    ck2(8'h00, 8'h80);
    run(8'h82, 8'hE7, 8'h00, 2);
    ck2(8'h00, 8'h00);
    run(8'hF4, 8'h00, 8'h00, 1);
    run(8'hB3, 8'h00, 8'h00, 1);
    run(8'hB0, 8'hE7, 8'h00, 2);
    ck2(8'hFF, 8'h00);
  endtask
  task t_cmp_jump;
    cj(8'hB4, 8'hFF, 8'h05, 16'h0003, 1'b0);
    cj(8'hB4, 8'h12, 8'h05, 16'h0008, 1'b0);
    cj(8'hB5, 8'hE0, 8'h10, 16'h0003, 1'b0);
    cj(8'hB8, 8'h01, 8'hFE, 16'h0001, 1'b1);
    cj(8'hB6, 8'h00, 8'h40, 16'h0003, 1'b0);
  endtask
  task t_page_jump;
    p = code_addr_o + 16'h0003;
    run(8'h21, 8'h23, 8'h00, 2);
    `CIA_CK(code_addr_o, {p[15:11], 3'b001, 8'h23})
    p = code_addr_o + 16'h0003;
    run(8'hE1, 8'h45, 8'h00, 2);
    `CIA_CK(code_addr_o, {p[15:11], 3'b111, 8'h45})
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    t_reset;
    t_acc;
    t_add_carry;
    t_port;
    t_bit;
    t_cmp_jump;
    t_page_jump;
    test_done;
  end
  // the run needs well under a hundred cycles; this is twenty times more
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
endmodule // cpu_instr_add_with_carry_to_cpl_tb
`default_nettype wire
